// [src/timer16_defs.svh]
// register offsets, field positions, reset values and timing of the 16-bit timer
`ifndef TIMER16_DEFS_SVH
`define TIMER16_DEFS_SVH
`define ADDR_IRQ_CTRL 8'h0B
`define ADDR_FLAGS    8'h0C
`define ADDR_CNT_LO   8'h0E
`define ADDR_CNT_HI   8'h0F
`define ADDR_TCTRL    8'h10
`define ADDR_IRQ_EN   8'h8C
`define TC_ON         0
`define TC_SRC        1
`define TC_SYNC_DIS   2
`define TC_OSC_EN     3
`define TC_PS_LSB     4
`define TC_PS_MSB     5
`define TC_GATE_EN    6
`define IC_PERIPH_EN  6
`define IC_GLOBAL_EN  7
`define FLAG_OVF      0
`define EN_OVF        0
`define TCTRL_RST     7'h00
`define CNT_RST       16'h0000
`define CNT_MAX       16'hFFFF
`define INSTR_DIV     4
`endif

// [src/timer16_pkg.sv]
// types shared by the 16-bit timer modules
package timer16_pkg;
  typedef enum logic [2:0]
  {
    MODE_TIMER = 3'b001,
    MODE_SYNC  = 3'b010,
    MODE_ASYNC = 3'b100
  } mode_t;
  typedef logic [1:0] prescale_t;
endpackage

// [src/timer16_prescaler.sv]
// 1/2/4/8 prescaler in front of the 16-bit count
`timescale 1ns/1ps
module timer16_prescaler
  import timer16_pkg::*;
(
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_nrst,
  // control
  input  wire logic      i_tick,
  input  wire logic      i_clear,
  input  wire prescale_t i_sel,
  // divided tick
  output logic           o_tick
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [2:0] mask;

  always_comb
  begin
    case (i_sel)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
    o_tick = i_tick && !i_clear && ((cnt_q & mask) == mask);
    cnt_d = cnt_q;
    if (i_clear)
      cnt_d = 3'h0;
    else if (i_tick)
      cnt_d = 3'(cnt_q + 3'h1);
  end

  // counter cannot be read or written over the bus; a count write only clears it
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_d;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_clear;
    i_clear |=> (cnt_q == 3'h0);
  endproperty
  a_clear: assert property (p_clear)
    else $error("prescale counter not cleared by count write");

  property p_ratio;
    o_tick |-> ((i_sel == 2'h0) || (i_sel == 2'h1 && cnt_q[0])
      || (i_sel == 2'h2 && cnt_q[1:0] == 2'h3) || (i_sel == 2'h3 && cnt_q == 3'h7));
  endproperty
  a_ratio: assert property (p_ratio)
    else $error("prescaler tick at wrong phase for selected ratio");
endmodule

// [src/timer16.sv]
// 16-bit timer/counter with prescaler, gate, overflow flag and register port
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "timer16_defs.svh"
module timer16
  import timer16_pkg::*;
#(
  parameter int INSTR_DIV = `INSTR_DIV
)
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // system state
  input  wire logic       i_sleep,
  input  wire logic       i_internal_oscillator,
  // pins
  input  wire logic       i_ext_count_clock,
  input  wire logic       i_low_power_crystal,
  input  wire logic       i_count_gate_n,
  // outputs
  output logic            o_irq,
  output logic            o_wake,
  output logic            o_crystal_osc_enable
);
  localparam int DW = (INSTR_DIV > 1) ? $clog2(INSTR_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(INSTR_DIV - 1);

  // registers
  logic [15:0]   cnt_q, cnt_d;
  logic [6:0]    tctrl_q, tctrl_d;
  logic          flag_q, flag_d;
  logic          ovf_en_q, ovf_en_d;
  logic          periph_en_q, periph_en_d;
  logic          global_en_q, global_en_d;
  logic [7:0]    rdata_q, rdata_d;
  logic [DW-1:0] div_q, div_d;
  logic [2:0]    src_sync_q, src_sync_d;
  logic [2:0]    gate_sync_q, gate_sync_d;
  logic          src_lvl_q, src_lvl_d;
  logic          gate_lvl_q, gate_lvl_d;
  logic          armed_q, armed_d;
  logic          pend_q, pend_d;

  // combinational
  mode_t mode;
  logic  src_raw;
  logic  instr_tick;
  logic  ext_rise;
  logic  ext_fall;
  logic  rise_ok;
  logic  src_tick;
  logic  gate_open;
  logic  run;
  logic  inc;
  logic  wr_lo;
  logic  wr_hi;
  logic  cnt_wr;
  logic  wrap;

  always_comb
  begin
    wr_lo  = i_wr && (i_addr == `ADDR_CNT_LO);
    wr_hi  = i_wr && (i_addr == `ADDR_CNT_HI);
    cnt_wr = wr_lo || wr_hi;
    // crystal only usable while the core runs from the internal oscillator
    src_raw = (tctrl_q[`TC_OSC_EN] && i_internal_oscillator) ? i_low_power_crystal
                                                             : i_ext_count_clock;
    if (!tctrl_q[`TC_SRC])
      mode = MODE_TIMER;
    else if (tctrl_q[`TC_SYNC_DIS])
      mode = MODE_ASYNC;
    else
      mode = MODE_SYNC;
  end

  // pin synchronisers and instruction-cycle divider
  always_comb
  begin
    src_sync_d  = {src_sync_q[1:0], src_raw};
    gate_sync_d = {gate_sync_q[1:0], i_count_gate_n};
    src_lvl_d   = (src_sync_q[1] == src_sync_q[2]) ? src_sync_q[2] : src_lvl_q;
    gate_lvl_d  = (gate_sync_q[1] == gate_sync_q[2]) ? gate_sync_q[2] : gate_lvl_q;
    ext_rise    = src_lvl_d && !src_lvl_q;
    ext_fall    = !src_lvl_d && src_lvl_q;
    // core clock stops in sleep, so instruction cycles stop too
    instr_tick  = !i_sleep && (div_q == DIV_LAST);
    if (i_sleep)
      div_d = div_q;
    else if (div_q == DIV_LAST)
      div_d = '0;
    else
      div_d = DW'(div_q + 1'b1);
  end

  // counting path
  always_comb
  begin
    gate_open = !tctrl_q[`TC_GATE_EN] || !gate_lvl_q;
    run       = tctrl_q[`TC_ON] && gate_open;
    rise_ok   = ext_rise && armed_q;
    armed_d   = armed_q;
    if (!(tctrl_q[`TC_ON] && tctrl_q[`TC_SRC]))
      armed_d = 1'b0;
    else if (ext_fall)
      armed_d = 1'b1;
    pend_d = 1'b0;
    case (mode)
      MODE_TIMER:
      begin
        src_tick = instr_tick;
      end
      MODE_SYNC:
      begin
        // edge waits for the next instruction cycle boundary
        src_tick = instr_tick && (pend_q || rise_ok);
        pend_d   = tctrl_q[`TC_ON] && !instr_tick && (pend_q || rise_ok);
      end
      MODE_ASYNC:
      begin
        // independent of the core clock enable, so it runs in sleep
        src_tick = rise_ok;
      end
      default:
      begin
        src_tick = 1'b0;
      end
    endcase
  end

  timer16_prescaler u_presc
  (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_tick  (run && src_tick),
    .i_clear (cnt_wr),
    .i_sel   (tctrl_q[`TC_PS_MSB:`TC_PS_LSB]),
    .o_tick  (inc)
  );

  // register file and count
  always_comb
  begin
    wrap        = inc && !cnt_wr && (cnt_q == `CNT_MAX);
    cnt_d       = cnt_q;
    tctrl_d     = tctrl_q;
    flag_d      = flag_q;
    ovf_en_d    = ovf_en_q;
    periph_en_d = periph_en_q;
    global_en_d = global_en_q;
    rdata_d     = 8'h00;
    // a write racing an increment wins; software should stop first
    if (wr_lo)
      cnt_d = {cnt_q[15:8], i_wdata};
    else if (wr_hi)
      cnt_d = {i_wdata, cnt_q[7:0]};
    else if (inc)
      cnt_d = 16'(cnt_q + 16'h0001);
    if (i_wr)
    begin
      case (i_addr)
        `ADDR_TCTRL:    tctrl_d = i_wdata[6:0];
        `ADDR_FLAGS:    flag_d = i_wdata[`FLAG_OVF];
        `ADDR_IRQ_EN:   ovf_en_d = i_wdata[`EN_OVF];
        `ADDR_IRQ_CTRL:
        begin
          periph_en_d = i_wdata[`IC_PERIPH_EN];
          global_en_d = i_wdata[`IC_GLOBAL_EN];
        end
        default:        ;
      endcase
    end
    // a wrap in the clearing cycle keeps the flag set
    if (wrap)
      flag_d = 1'b1;
    if (i_rd)
    begin
      case (i_addr)
        `ADDR_CNT_LO:   rdata_d = cnt_q[7:0];
        `ADDR_CNT_HI:   rdata_d = cnt_q[15:8];
        `ADDR_TCTRL:    rdata_d = {1'b0, tctrl_q};
        `ADDR_FLAGS:    rdata_d = {7'h00, flag_q};
        `ADDR_IRQ_EN:   rdata_d = {7'h00, ovf_en_q};
        `ADDR_IRQ_CTRL: rdata_d = {global_en_q, periph_en_q, 6'h00};
        default:        rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q       <= `CNT_RST;
      tctrl_q     <= `TCTRL_RST;
      flag_q      <= 1'b0;
      ovf_en_q    <= 1'b0;
      periph_en_q <= 1'b0;
      global_en_q <= 1'b0;
      rdata_q     <= 8'h00;
      div_q       <= '0;
      src_sync_q  <= 3'h0;
      gate_sync_q <= 3'h0;
      src_lvl_q   <= 1'b0;
      gate_lvl_q  <= 1'b0;
      armed_q     <= 1'b0;
      pend_q      <= 1'b0;
    end
    else
    begin
      cnt_q       <= cnt_d;
      tctrl_q     <= tctrl_d;
      flag_q      <= flag_d;
      ovf_en_q    <= ovf_en_d;
      periph_en_q <= periph_en_d;
      global_en_q <= global_en_d;
      rdata_q     <= rdata_d;
      div_q       <= div_d;
      src_sync_q  <= src_sync_d;
      gate_sync_q <= gate_sync_d;
      src_lvl_q   <= src_lvl_d;
      gate_lvl_q  <= gate_lvl_d;
      armed_q     <= armed_d;
      pend_q      <= pend_d;
    end
  end

  assign o_rdata              = rdata_q;
  assign o_irq                = flag_q && ovf_en_q && periph_en_q && global_en_q;
  assign o_wake               = flag_q && ovf_en_q && periph_en_q;
  assign o_crystal_osc_enable = tctrl_q[`TC_OSC_EN];

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_wrap;
    (inc && !cnt_wr && cnt_q == 16'hFFFF) |=> (cnt_q == 16'h0000) && flag_q;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap did not give zero count with flag set");

  // request may only rise after a wrap or a write to the flag or an enable
  property p_irq;
    $rose(o_irq) |-> $past(wrap || (i_wr && (i_addr == `ADDR_FLAGS
      || i_addr == `ADDR_IRQ_EN || i_addr == `ADDR_IRQ_CTRL)));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt rose without a wrap or an enable or flag write");

  property p_flag_hold;
    (flag_q && !(i_wr && i_addr == 8'h0C && !i_wdata[0])) |=> flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("overflow flag dropped without software clear");

  property p_stopped;
    (!tctrl_q[0] && !cnt_wr) |=> $stable(cnt_q);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("count moved while timer off");

  property p_gated;
    (tctrl_q[6] && gate_lvl_q && !cnt_wr) |=> $stable(cnt_q);
  endproperty
  a_gated: assert property (p_gated)
    else $error("count moved while gate closed");

  property p_armed;
    (mode != MODE_TIMER && !armed_q && !pend_q) |-> !src_tick;
  endproperty
  a_armed: assert property (p_armed)
    else $error("counter edge taken before a falling edge");

  property p_timer_cycle;
    (mode == MODE_TIMER && inc) |-> instr_tick && !i_sleep;
  endproperty
  a_timer_cycle: assert property (p_timer_cycle)
    else $error("timer mode advanced off an instruction cycle");

  property p_read_lo;
    (i_rd && i_addr == 8'h0E) |=> (o_rdata == $past(cnt_q[7:0]));
  endproperty
  a_read_lo: assert property (p_read_lo)
    else $error("low byte read returned wrong value");

  property p_async_sleep;
    (mode == MODE_ASYNC && run && rise_ok && tctrl_q[5:4] == 2'h0 && !cnt_wr)
      |=> (cnt_q == 16'($past(cnt_q) + 16'h0001));
  endproperty
  a_async_sleep: assert property (p_async_sleep)
    else $error("asynchronous edge not counted");

  property p_flag_clear;
    (i_wr && i_addr == `ADDR_FLAGS && !i_wdata[`FLAG_OVF] && !wrap) |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("overflow flag not cleared by software write of zero");

  property p_sync_align;
    (mode == MODE_SYNC && src_tick) |-> instr_tick;
  endproperty
  a_sync_align: assert property (p_sync_align)
    else $error("synchronous counter edge taken off an instruction cycle");
endmodule

// [verification/ext_source.sv]
// model of the external count clock, crystal and gate sources
`timescale 1ns/1ps
module ext_source
(
  // clock
  input  wire logic i_clk,
  // pins toward the timer
  output logic      o_ext_count_clock,
  output logic      o_low_power_crystal,
  output logic      o_count_gate_n
);
  initial
  begin
    o_ext_count_clock   = 1'b1;
    o_low_power_crystal = 1'b1;
    o_count_gate_n      = 1'b0;
  end
  task automatic set_pin(input bit x, input bit v);
    if (x)
      o_low_power_crystal <= v;
    else
      o_ext_count_clock <= v;
  endtask
  task automatic set_gate(input bit v);
    @(posedge i_clk);
    o_count_gate_n <= v;
  endtask
  // 20-cycle levels: the 3-stage pin sync never misses one
  task automatic pulses(input int n, input bit x);
    repeat (n)
    begin
      @(posedge i_clk);
      set_pin(x, 1'b0);
      repeat (20) @(posedge i_clk);
      set_pin(x, 1'b1);
      repeat (20) @(posedge i_clk);
    end
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`include "timer16_defs.svh"
module tb_top;
  logic        i_clk, i_nrst, i_wr, i_rd, i_sleep, i_internal_oscillator;
  logic [7:0]  i_addr, i_wdata, o_rdata, rv;
  logic        o_irq, o_wake, o_crystal_osc_enable;
  logic [15:0] cnt, hold;
  wire         ext_clk, xtal, gate_n;
  int          miscompares, cmp_count;
  logic [7:0]  regs [7] = '{8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h8C, 8'h11};

  always #2.5 i_clk = ~i_clk;

  timer16 #(.INSTR_DIV(2)) dut
  (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
    .i_internal_oscillator(i_internal_oscillator), .i_ext_count_clock(ext_clk),
    .i_low_power_crystal(xtal), .i_count_gate_n(gate_n), .o_irq(o_irq),
    .o_wake(o_wake), .o_crystal_osc_enable(o_crystal_osc_enable)
  );
  ext_source src
  (
    .i_clk(i_clk), .o_ext_count_clock(ext_clk), .o_low_power_crystal(xtal),
    .o_count_gate_n(gate_n)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic rd16;
    rd(`ADDR_CNT_LO);
    cnt[7:0] = rv;
    rd(`ADDR_CNT_HI);
    cnt[15:8] = rv;
  endtask
  // stop first: a write racing an increment wins and the increment is lost
  task automatic clr;
    wr(`ADDR_TCTRL, 8'h00);
    wr(`ADDR_CNT_HI, 8'h00);
    wr(`ADDR_CNT_LO, 8'h00);
  endtask
  task automatic run(input logic [7:0] c, input int n, input bit x, input logic [15:0] e);
    clr();
    wr(`ADDR_TCTRL, c);
    src.pulses(n, x);
    wr(`ADDR_TCTRL, 8'h00);
    rd16();
    check(cnt, e);
  endtask

  initial
  begin
    #500000;
    miscompares++;
    end_of_test();
  end

  initial
  begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_sleep = 1'b0;
    i_internal_oscillator = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    foreach (regs[k])
    begin
      rd(regs[k]);
      check(rv, 16'h0000);
    end
    check({o_irq, o_wake, o_crystal_osc_enable}, 16'h0000);
    wr(`ADDR_CNT_HI, 8'h12);
    wr(`ADDR_CNT_LO, 8'h34);
    rd16();
    check(cnt, 16'h1234);
    wr(`ADDR_TCTRL, 8'hFF);
    rd(`ADDR_TCTRL);
    check(rv, 16'h007F);
    check(o_crystal_osc_enable, 16'h0001);
    // timer mode, divide by 2: about 400 / 2 / 2 counts
    clr();
    wr(`ADDR_TCTRL, 8'h11);
    repeat (400) @(posedge i_clk);
    wr(`ADDR_TCTRL, 8'h00);
    rd16();
    check(cnt >= 16'd98 && cnt <= 16'd101, 16'h0001);
    hold = cnt;
    repeat (100) @(posedge i_clk);
    rd16();
    check(cnt, hold);
    for (int s = 0; s < 4; s++)
      run(8'h07 | 8'(s << 4), 16, 1'b0, 16'(16 >> s));
    run(8'h03, 8, 1'b0, 16'd8);
    src.set_pin(1'b0, 1'b0);
    run(8'h07, 8, 1'b0, 16'd7);
    src.set_gate(1'b1);
    run(8'h47, 8, 1'b0, 16'd0);
    run(8'h41, 2, 1'b0, 16'd0);
    src.set_gate(1'b0);
    run(8'h43, 8, 1'b0, 16'd8);
    i_internal_oscillator <= 1'b1;
    run(8'h0F, 8, 1'b1, 16'd8);
    i_sleep <= 1'b1;
    run(8'h07, 8, 1'b0, 16'd8);
    run(8'h03, 8, 1'b0, 16'd0);
    i_sleep <= 1'b0;
    // divide by 8: 5 edges, clear by count write, 7 more give no count
    clr();
    wr(`ADDR_TCTRL, 8'h37);
    src.pulses(5, 1'b0);
    wr(`ADDR_CNT_LO, 8'h00);
    src.pulses(7, 1'b0);
    wr(`ADDR_TCTRL, 8'h00);
    rd16();
    check(cnt, 16'h0000);
    clr();
    wr(`ADDR_FLAGS, 8'h00);
    wr(`ADDR_CNT_HI, 8'hFF);
    wr(`ADDR_CNT_LO, 8'hFD);
    wr(`ADDR_IRQ_EN, 8'h01);
    wr(`ADDR_IRQ_CTRL, 8'hC0);
    wr(`ADDR_TCTRL, 8'h01);
    repeat (20) @(posedge i_clk);
    wr(`ADDR_TCTRL, 8'h00);
    rd(`ADDR_FLAGS);
    check(rv, 16'h0001);
    check(o_irq, 16'h0001);
    rd16();
    check(cnt < 16'h0010, 16'h0001);
    wr(`ADDR_FLAGS, 8'h00);
    @(posedge i_clk);
    #1 check(o_irq, 16'h0000);
    wr(`ADDR_FLAGS, 8'h01);
    for (int e = 0; e < 8; e++)
    begin
      wr(`ADDR_IRQ_CTRL, {e[2], e[1], 6'h00});
      wr(`ADDR_IRQ_EN, {7'h00, e[0]});
      @(posedge i_clk);
      #1 check(o_irq, 16'(e == 7));
      check(o_wake, 16'(e[1] & e[0]));
    end
    // reset with the timer stopped and flag, enables and count all nonzero
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(`ADDR_TCTRL);
    check(rv, 16'h0000);
    check({o_irq, o_wake}, 16'h0000);
    rd16();
    check(cnt, 16'h0000);
    end_of_test();
  end
endmodule
